// >>> logic/rdw_defines.svh
// Offsets, field positions, reset values and timing counts of the write-back
`ifndef RDW_DEFINES_SVH
`define RDW_DEFINES_SVH

`define RDW_ADDR_W           4
`define RDW_REG_CTRL         4'h0
`define RDW_REG_STATUS       4'h1
`define RDW_REG_MASK         4'h2
`define RDW_REG_LAST         4'h3
`define RDW_REG_COUNT        4'h4

`define RDW_BIT_VALID        31
`define RDW_BIT_LIST_END     30
`define RDW_POS_HI           29
`define RDW_POS_LO           28
`define RDW_BIT_FRAME_ERR    27
`define RDW_BIT_OVERFLOW     9
`define RDW_BIT_ABORT        8
`define RDW_BIT_MULTICAST    7
`define RDW_BIT_RESIDUAL     4
`define RDW_BIT_TOO_LONG     3
`define RDW_BIT_TOO_SHORT    2
`define RDW_BIT_PHY_ERR      1
`define RDW_BIT_CRC_ERR      0

`define RDW_POS_MIDDLE       2'h0
`define RDW_POS_END          2'h1
`define RDW_POS_START        2'h2
`define RDW_POS_WHOLE        2'h3

`define RDW_CTRL_RESET       32'h0000_0000
`define RDW_MASK_RESET       3'h0

`define RDW_CTRL_MCAST_ERR   0

`define RDW_IRQ_WB           0
`define RDW_IRQ_ERR          1
`define RDW_IRQ_INCOMPLETE   2

`define RDW_WB_LATENCY_NS    10
`define RDW_CLK_PERIOD_NS    10
`define RDW_WB_CYCLES        ((`RDW_WB_LATENCY_NS + `RDW_CLK_PERIOD_NS - 1) \
                              / `RDW_CLK_PERIOD_NS)

`endif

// >>> logic/rdw_pkg.sv
// Types shared by the descriptor status write-back logic
package rdw_pkg;

    typedef enum logic [1:0]
    {
        RDW_POS_MIDDLE,
        RDW_POS_END,
        RDW_POS_START,
        RDW_POS_WHOLE
    } rdw_pos_t;

    typedef struct packed
    {
        logic overflow;
        logic multicast;
        logic residual;
        logic tooLong;
        logic tooShort;
        logic phyErr;
        logic crcErr;
    } rdw_events_t;

    typedef struct packed
    {
        logic        bufferFull;
        logic        frameEnd;
        rdw_events_t events;
    } rdw_buf_done_t;

    typedef struct packed
    {
        logic        valid;
        logic        listEnd;
        logic [1:0]  position;
        logic        frameError;
        logic [26:0] eventBits;
    } rdw_word_t;

endpackage

// >>> logic/rdw_status_format.sv
// Builds descriptor word zero from the frame position and collected events
`timescale 1ns/1ps
`include "rdw_defines.svh"

module rdw_status_format
(
    input  wire logic                 listEnd,
    input  wire logic                 firstBuf,
    input  wire logic                 lastBuf,
    input  wire logic                 mcastToErr,
    input  wire rdw_pkg::rdw_events_t ev,
    output      rdw_pkg::rdw_word_t   word,
    output      logic                 incomplete
);

    wire logic [1:0] posCode;
    wire logic       abortEv;
    wire logic       frameErr;
    wire logic [26:0] bits;

    // Position from whether this buffer opens and whether it closes the frame
    assign posCode = {firstBuf, lastBuf};

    assign abortEv = ev.tooLong | ev.tooShort | ev.phyErr | ev.crcErr;

    assign frameErr = abortEv | (mcastToErr & ev.multicast);

    assign incomplete = abortEv | ev.residual;

    // Reserved positions are driven zero, so the word stays clean even if
    // software left junk in them
    assign bits = {17'h0_0000,
                   ev.overflow,
                   abortEv,
                   ev.multicast,
                   2'h0,
                   ev.residual,
                   ev.tooLong,
                   ev.tooShort,
                   ev.phyErr,
                   ev.crcErr};

    assign word.valid      = 1'b0;
    assign word.listEnd    = listEnd;
    assign word.position   = posCode;
    assign word.frameError = frameErr;
    assign word.eventBits  = bits;

endmodule // rdw_status_format

// >>> logic/rdw_writeback.sv
// Descriptor status write-back engine with its control registers
`timescale 1ns/1ps
`include "rdw_defines.svh"

module rdw_writeback
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Buffer completion from the receive transfer
    input  wire logic                   doneValid,
    input  wire rdw_pkg::rdw_buf_done_t doneInfo,
    input  wire logic                   listEnd,
    output      logic                   doneReady,
    // Descriptor memory write port
    output      logic                   wbValid,
    output      logic [31:0]            wbData,
    input  wire logic                   wbReady,
    // Register port
    input  wire logic [3:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output      logic [31:0]            regRdata,
    output      logic                   irq
);

    logic                  rstSync1_r;
    logic                  rstSync2_r;
    wire  logic            rstN;

    logic                  inFrame_r;
    logic                  inFrame_nxt;
    rdw_pkg::rdw_events_t  evAcc_r;
    rdw_pkg::rdw_events_t  evAcc_nxt;
    logic                  wbValid_r;
    logic [31:0]           wbData_r;
    logic                  ctrlMcast_r;
    logic [2:0]            status_r;
    logic [2:0]            status_nxt;
    logic [2:0]            mask_r;
    logic [31:0]           lastWord_r;
    logic [15:0]           wbCount_r;
    logic [31:0]           regRdata_r;

    wire  logic            take;
    wire  logic            lastBuf;
    wire  rdw_pkg::rdw_events_t evNow;
    wire  rdw_pkg::rdw_word_t   fmtWord;
    wire  logic            fmtIncomplete;
    wire  logic            wrCtrl;
    wire  logic            wrStatus;
    wire  logic            wrMask;
    wire  logic [2:0]      evSet;
    wire  logic [31:0]     rdMux;

    // Reset is released synchronously so no flop sees a ragged release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstN = rstSync2_r;

    // One word held at a time; a stalled memory stalls the receive side
    assign doneReady = !wbValid_r || wbReady;
    assign take      = doneValid && doneReady;

    // A full buffer continues the frame; frame end or error closes it
    assign lastBuf = doneInfo.frameEnd || !doneInfo.bufferFull;

    // Events stay with the frame across buffers, reported in the last one
    assign evNow = evAcc_r | doneInfo.events;

    rdw_status_format u_format
    (
        .listEnd    (listEnd),
        .firstBuf   (!inFrame_r),
        .lastBuf    (lastBuf),
        .mcastToErr (ctrlMcast_r),
        .ev         (lastBuf ? evNow : '0),
        .word       (fmtWord),
        .incomplete (fmtIncomplete)
    );

    assign inFrame_nxt = take ? !lastBuf : inFrame_r;
    assign evAcc_nxt   = take ? (lastBuf ? '0 : evNow) : evAcc_r;

    // Register decode
    assign wrCtrl   = regWr && (regAddr == `RDW_REG_CTRL);
    assign wrStatus = regWr && (regAddr == `RDW_REG_STATUS);
    assign wrMask   = regWr && (regAddr == `RDW_REG_MASK);

    assign evSet[`RDW_IRQ_WB]         = take;
    assign evSet[`RDW_IRQ_ERR]        = take && fmtWord.frameError;
    assign evSet[`RDW_IRQ_INCOMPLETE] = take && fmtIncomplete;

    // A new event wins over a write-one clear in the same cycle
    assign status_nxt = (status_r & ~(wrStatus ? regWdata[2:0] : 3'h0))
                        | evSet;

    assign rdMux = (regAddr == `RDW_REG_CTRL)   ? {31'h0, ctrlMcast_r} :
                   (regAddr == `RDW_REG_STATUS) ? {29'h0, status_r} :
                   (regAddr == `RDW_REG_MASK)   ? {29'h0, mask_r} :
                   (regAddr == `RDW_REG_LAST)   ? lastWord_r :
                   (regAddr == `RDW_REG_COUNT)  ? {16'h0, wbCount_r} :
                   32'h0;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            inFrame_r <= 1'b0;
            evAcc_r   <= '0;
        end
        else
        begin
            inFrame_r <= inFrame_nxt;
            evAcc_r   <= evAcc_nxt;
        end
    end

    // Valid bit clear and status go out as one word
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wbValid_r <= 1'b0;
            wbData_r  <= 32'h0;
        end
        else if (take)
        begin
            wbValid_r <= 1'b1;
            wbData_r  <= fmtWord;
        end
        else if (wbReady)
        begin
            wbValid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            ctrlMcast_r <= 1'b0;
            mask_r      <= `RDW_MASK_RESET;
            status_r    <= 3'h0;
        end
        else
        begin
            if (wrCtrl)
                ctrlMcast_r <= regWdata[`RDW_CTRL_MCAST_ERR];
            if (wrMask)
                mask_r <= regWdata[2:0];
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            lastWord_r <= 32'h0;
            wbCount_r  <= 16'h0;
            regRdata_r <= 32'h0;
        end
        else
        begin
            if (take)
            begin
                lastWord_r <= fmtWord;
                wbCount_r  <= wbCount_r + 16'h1;
            end
            regRdata_r <= regRd ? rdMux : 32'h0;
        end
    end

    assign wbValid  = wbValid_r;
    assign wbData   = wbData_r;
    assign regRdata = regRdata_r;
    assign irq      = |(status_r & mask_r);

endmodule // rdw_writeback

// >>> test/rdw_mem_model.sv
// Descriptor memory that accepts write-back words, sometimes slowly
`timescale 1ns/1ps
module rdw_mem_model
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic slow,
    output      logic wbReady
);
    integer seed = 32'hf2fd;
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            wbReady <= 1'b0;
        else
            wbReady <= !slow || ($random(seed) % 3 == 0);
endmodule // rdw_mem_model

// >>> test/rdw_writeback_asserts.sv
// Port assertions of the descriptor status write-back
`timescale 1ns/1ps
module rdw_writeback_asserts
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   doneValid,
    input wire rdw_pkg::rdw_buf_done_t doneInfo,
    input wire logic                   listEnd,
    input wire logic                   doneReady,
    input wire logic                   wbValid,
    input wire logic [31:0]            wbData,
    input wire logic                   wbReady,
    input wire logic                   irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire take    = doneValid && doneReady;
    wire closing = !doneInfo.bufferFull || doneInfo.frameEnd;

    a_take_answer: assert property (take |=> wbValid)
        else $error("no word after take");
    a_valid_clear: assert property (wbValid |-> !wbData[31])
        else $error("valid bit left set");
    a_abort_mirror: assert property
        (wbValid |-> wbData[8] == |wbData[3:0])
        else $error("abort bit wrong");
    a_error_flag: assert property (wbValid && wbData[8] |-> wbData[27])
        else $error("error flag missing");
    a_error_cause: assert property
        (wbValid && !wbData[8] && !wbData[7] |-> !wbData[27])
        else $error("error flag without cause");
    a_reserved_zero: assert property
        (wbValid |-> wbData[26:10] == 17'h0 && wbData[6:5] == 2'h0)
        else $error("reserved bits set");
    a_pos_close: assert property (take |=> wbData[28] == $past(closing))
        else $error("position end bit wrong");
    a_middle_quiet: assert property
        (wbValid && !wbData[28] |-> wbData[27:0] == 28'h0)
        else $error("status in open word");
    a_word_hold: assert property
        (wbValid && !wbReady |=> wbValid && $stable(wbData))
        else $error("word dropped in stall");
    a_crc_mirror: assert property
        (take && closing && doneInfo.events.crcErr |=> wbData[0])
        else $error("crc bit missing");
    c_open_word: cover property (take && !closing);
    c_middle: cover property (wbValid && wbData[29:28] == 2'h0);
    c_irq: cover property ($rose(irq));
    c_cut_frame: cover property
        (take && !doneInfo.bufferFull && !doneInfo.frameEnd);
endmodule // rdw_writeback_asserts

bind rdw_writeback rdw_writeback_asserts rdw_writeback_asserts_inst
(
    .clk(clk), .rst_b(rst_b), .doneValid(doneValid), .doneInfo(doneInfo),
    .listEnd(listEnd), .doneReady(doneReady), .wbValid(wbValid),
    .wbData(wbData), .wbReady(wbReady), .irq(irq)
);

// >>> test/tb_top.sv
// Self-checking bench of the descriptor status write-back
`timescale 1ns/1ps
`include "rdw_defines.svh"
module tb_top;
    logic                   clk, rst_b, doneValid, listEnd, doneReady;
    logic                   wbValid, wbReady, regWr, regRd, irq, slow, mcast;
    rdw_pkg::rdw_buf_done_t doneInfo;
    logic [31:0]            wbData, regWdata, regRdata;
    logic [3:0]             regAddr;
    logic [31:0]            expQ[$];
    logic [31:0]            rdExpQ[$];
    logic [31:0]            lastExp;
    string                  rdNameQ[$];
    logic                   rdPend = 1'b0;
    integer fail_count = 0, total_checks = 0, cycles = 0, seed = 32'hf2fd;

    rdw_writeback rdw_writeback_inst (.clk(clk), .rst_b(rst_b),
        .doneValid(doneValid), .doneInfo(doneInfo), .listEnd(listEnd),
        .doneReady(doneReady), .wbValid(wbValid), .wbData(wbData),
        .wbReady(wbReady), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
    rdw_mem_model rdw_mem_model_inst (.clk(clk), .rst_b(rst_b),
        .slow(slow), .wbReady(wbReady));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    // Expected read data is queued; the monitor compares it one cycle later
    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        regAddr <= a;
        regRd   <= 1'b1;
        rdExpQ.push_back(e);
        rdNameQ.push_back(n);
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
    endtask

    // Abort mirrors the length, phy and crc errors only
    function automatic logic [31:0] expw(logic le, logic [1:0] p,
                                         rdw_pkg::rdw_events_t e);
        logic ab;
        ab = e.tooLong | e.tooShort | e.phyErr | e.crcErr;
        expw = {1'b0, le, p, ab | (mcast & e.multicast), 17'h0, e.overflow,
                ab, e.multicast, 2'h0, e.residual, e.tooLong, e.tooShort,
                e.phyErr, e.crcErr};
    endfunction

    // Events go on the first buffer so the closing word must accumulate them
    task frame(input int n, input rdw_pkg::rdw_events_t e);
        logic [1:0] p;
        logic       le;
        logic       bf, fe;
        for (int k = 0; k < n; k++)
        begin
            le = 1'($random(seed));
            p = (n == 1) ? 2'h3 : (k == 0) ? 2'h2 : (k == n - 1) ? 2'h1 : 2'h0;
            // Closing buffer may end full, end short or be cut by an error
            bf = (k < n - 1) | 1'($random(seed));
            fe = (k == n - 1) & (bf | 1'($random(seed)));
            doneInfo  <= {bf, fe, (k == 0) ? e : 7'h0};
            listEnd   <= le;
            doneValid <= 1'b1;
            do @(posedge clk); while (!doneReady);
            lastExp = (k == n - 1) ? expw(le, p, e) : {1'b0, le, p, 28'h0};
            expQ.push_back(lastExp);
        end
        doneValid <= 1'b0;
        @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        if (wbValid && wbReady)
            check("word", expQ.size() ? expQ.pop_front() : 32'hx, wbData);
        if (rdPend)
            check(rdNameQ.pop_front(), rdExpQ.pop_front(), regRdata);
        rdPend <= regRd;
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test;
        end
    end

    initial
    begin
        {rst_b, doneValid, listEnd, regWr, regRd, slow, mcast} = 7'h0;
        doneInfo = '0;
        regAddr  = 4'h0;
        regWdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`RDW_REG_CTRL, 32'h0, "ctrl");
        rd(`RDW_REG_MASK, 32'h0, "mask");
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, 32'h0, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 7; i++)
            frame(1, 7'(1 << i));
        $display("test single events done");
        slow <= 1'b1;
        for (int n = 2; n < 7; n++)
            frame(n, 7'($random(seed)));
        slow <= 1'b0;
        $display("test multi buffer done");
        wr(`RDW_REG_CTRL, 32'h1);
        rd(`RDW_REG_CTRL, 32'h1, "ctrl");
        mcast = 1'b1;
        frame(1, 7'h20);
        wr(`RDW_REG_CTRL, 32'h0);
        mcast = 1'b0;
        frame(1, 7'h20);
        $display("test multicast done");
        repeat (10) @(posedge clk);
        wr(`RDW_REG_MASK, 32'h7);
        check("irq", 32'h1, {31'h0, irq});
        wr(`RDW_REG_STATUS, 32'h7);
        check("irq", 32'h0, {31'h0, irq});
        wr(`RDW_REG_MASK, 32'h0);
        frame(1, 7'h1);
        repeat (10) @(posedge clk);
        check("irq", 32'h0, {31'h0, irq});
        rd(`RDW_REG_STATUS, 32'h7, "status");
        rd(`RDW_REG_LAST, lastExp, "last");
        // Seven single, twenty multi-buffer, two multicast, one crc
        rd(`RDW_REG_COUNT, 32'h1e, "count");
        wr(`RDW_REG_MASK, 32'h4);
        check("irq", 32'h1, {31'h0, irq});
        wr(`RDW_REG_STATUS, 32'h4);
        check("irq", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        check("pending", 32'h0, 32'(expQ.size() + rdExpQ.size()));
        stop_test;
    end
endmodule // tb_top
